// [pkg/can_eti_pkg.sv]
// Constants, register map and state types of the CAN error, timing and interrupt block
package can_eti_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FAULT_TALLY = 8'h08;
  localparam logic [7:0] ADDR_BIT_TIMING = 8'h0c;
  localparam logic [7:0] ADDR_INT_CAUSE = 8'h10;
  localparam logic [7:0] ADDR_DIAG = 8'h14;
  localparam logic [7:0] ADDR_PRESC_EXT = 8'h18;

  // Control register bit positions
  localparam int CTL_HALT = 0;
  localparam int CTL_LINE_EN = 1;
  localparam int CTL_STAT_EN = 2;
  localparam int CTL_ERR_EN = 3;
  localparam int CTL_CFG_EN = 6;
  localparam int CTL_DIAG_EN = 7;

  // Diagnostic register bit positions
  localparam int DG_RX_MON = 7;
  localparam int DG_TX_LO = 5;
  localparam int DG_LOOP = 4;
  localparam int DG_LISTEN = 3;
  localparam int DG_DIRECT = 2;

  // Bit timing field positions
  localparam int BT_SEG2_LO = 12;
  localparam int BT_SEG1_LO = 8;
  localparam int BT_SJW_LO = 6;
  localparam int BT_PRESC_LO = 0;

  // Reset values
  localparam logic [2:0] RST_SEG2 = 3'h2;
  localparam logic [3:0] RST_SEG1 = 4'h3;
  localparam logic [1:0] RST_SJW = 2'h0;
  localparam logic [5:0] RST_PRESC = 6'h01;

  // Thresholds
  localparam logic [7:0] INBOUND_PASSIVE_LEVEL = 8'h80;
  localparam logic [8:0] OUTBOUND_OFF_LEVEL = 9'h100;
  localparam logic [7:0] WARN_LEVEL = 8'h60;
  localparam logic [7:0] OUTBOUND_PASSIVE_LEVEL = 8'h80;

  // Interrupt cause codes
  localparam logic [15:0] CAUSE_NONE = 16'h0000;
  localparam logic [15:0] CAUSE_STATUS = 16'h8000;
  localparam int NUM_OBJECTS = 32;

  // Transmit pin override encodings
  localparam logic [1:0] TXO_NORMAL = 2'h0;
  localparam logic [1:0] TXO_SAMPLE = 2'h1;
  localparam logic [1:0] TXO_DOMINANT = 2'h2;
  localparam logic [1:0] TXO_RECESSIVE = 2'h3;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  // Complete block state
  typedef struct packed {
    logic halt;
    logic line_en;
    logic stat_en;
    logic err_en;
    logic cfg_en;
    logic diag_en;
    logic bus_off;
    logic rx_ok;
    logic tx_ok;
    logic [2:0] lec;
    logic passive;
    logic [6:0] inbound_fault_tally;
    logic [7:0] outbound_fault_tally;
    logic [2:0] seg2;
    logic [3:0] seg1;
    logic [1:0] resync_jump_width;
    logic [5:0] presc;
    logic [3:0] presc_ext;
    logic [1:0] tx_ovr;
    logic loopback;
    logic listen_only;
    logic direct_buf;
    logic status_cause;
    logic [15:0] cause;
    logic [9:0] presc_cnt;
    logic tq_tick;
    logic [15:0] rdata;
  } state_type;

  localparam state_type STATE_RESET = '{
    halt: 1'b1, line_en: 1'b0, stat_en: 1'b0, err_en: 1'b0, cfg_en: 1'b0,
    diag_en: 1'b0, bus_off: 1'b0, rx_ok: 1'b0, tx_ok: 1'b0, lec: 3'h0,
    passive: 1'b0, inbound_fault_tally: 7'h00, outbound_fault_tally: 8'h00, seg2: RST_SEG2, seg1: RST_SEG1,
    resync_jump_width: RST_SJW, presc: RST_PRESC, presc_ext: 4'h0, tx_ovr: TXO_NORMAL,
    loopback: 1'b0, listen_only: 1'b0, direct_buf: 1'b0, status_cause: 1'b0,
    cause: CAUSE_NONE, presc_cnt: 10'h000, tq_tick: 1'b0, rdata: 16'h0000};

endpackage

// [sim/can_bus_node.sv]
// Other nodes on the CAN bus, seen as one wired-and line
`timescale 1ns/1ps
module can_bus_node (
  // Pin from the block
  input wire logic can_tx,
  // Another node pulling the bus dominant
  input wire logic node_dom,
  // Resolved bus level back to the block
  output logic bus_level
);
  // Dominant wins; the line rests recessive unless either side drives it low, never left unknown
  assign bus_level = can_tx & ~node_dom;
endmodule // can_bus_node

// [sim/can_error_timing_irq_test_tb_top.sv]
// Self-checking bench for the CAN error, timing and interrupt block
`timescale 1ns/1ps
module can_error_timing_irq_test_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  can_eti_pkg::reg_req_type req = '0;
  logic [15:0] reg_rdata;
  logic rx_error = 1'b0, rx_done = 1'b0, tx_error = 1'b0, lec_valid = 1'b0, tx_done = 1'b0;
  logic recovery_done = 1'b0, core_tx = 1'b1, sample_point = 1'b0, node_dom = 1'b0;
  logic [3:0] rx_error_inc = 4'h0, tx_error_inc = 4'h0;
  logic [2:0] lec_code = 3'h0;
  logic [31:0] pend = 32'h0, seed = 32'h95f28667;
  logic core_rx, can_rx, can_tx, tq_tick, halt_hold, tx_inhibit, irq;
  logic loopback_active, listen_only_active, direct_buffer_mode;
  logic [3:0] phase_seg2_tq;
  logic [4:0] time_seg1_tq;
  logic [2:0] jump_width_tq;
  int fails = 0;
  int check_count = 0;

  can_error_timing_irq_test i_dut (.clk(clk), .sys_rst(sys_rst), .reg_req(req),
    .reg_rdata(reg_rdata), .rx_error(rx_error), .rx_error_inc(rx_error_inc),
    .rx_done(rx_done), .tx_error(tx_error), .tx_error_inc(tx_error_inc), .tx_done(tx_done),
    .lec_valid(lec_valid), .lec_code(lec_code), .recovery_done(recovery_done),
    .object_pending_flag(pend), .core_tx(core_tx), .sample_point(sample_point),
    .core_rx(core_rx), .can_rx(can_rx), .can_tx(can_tx), .tq_tick(tq_tick),
    .phase_seg2_tq(phase_seg2_tq), .time_seg1_tq(time_seg1_tq),
    .jump_width_tq(jump_width_tq), .halt_hold(halt_hold), .tx_inhibit(tx_inhibit),
    .loopback_active(loopback_active), .listen_only_active(listen_only_active),
    .direct_buffer_mode(direct_buffer_mode), .irq(irq));

  can_bus_node i_node (.can_tx(can_tx), .node_dom(node_dom), .bus_level(can_rx));

  // 50 MHz clock
  always #10 clk = ~clk;

  // Pseudo-random source, fixed seed so every run repeats
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  // Highest-priority cause: status first, then lowest object number
  function automatic logic [15:0] exp_cause(input logic [31:0] p, input logic s);
    exp_cause = 16'h0000;
    for (int i = 31; i >= 0; i--) begin
      if (p[i]) begin
        exp_cause = 16'(i + 1);
      end
    end
    if (s) begin
      exp_cause = 16'h8000;
    end
  endfunction

  // Expected pin level for each override code
  function automatic logic exp_tx(input int m, input logic c, input logic sp);
    exp_tx = (m == 0) ? c : (m == 1) ? sp : (m == 3);
  endfunction

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single-cycle strobes; only whole 16-bit accesses are ever made
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= {a, d, 2'b10};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    req <= {a, 16'h0000, 2'b01};
    @(posedge clk);
    req <= '0;
    #1 d = reg_rdata;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk_word(d, exp);
  endtask

  // One-cycle event pulse from the protocol engine
  task automatic ev(input int k, input logic [3:0] inc);
    @(posedge clk);
    rx_error <= (k == 0);
    rx_done <= (k == 1);
    tx_error <= (k == 2);
    lec_valid <= (k == 3);
    recovery_done <= (k == 4);
    tx_done <= (k == 5);
    rx_error_inc <= inc;
    tx_error_inc <= inc;
    lec_code <= inc[2:0];
    @(posedge clk);
    {rx_error, rx_done, tx_error, lec_valid, recovery_done, tx_done} <= 6'h00;
  endtask

  // Edges until the next quantum tick, bounded so a dead divider cannot hang
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (tq_tick !== 1'b1 && n < 200);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog, tens of times the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    logic [31:0] pv [4];
    logic [15:0] v, d;
    logic nd;
    int n;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    chk_bit(halt_hold, 1'b1);
    // Inbound tally up to the passive level and back, error-change causes enabled
    wr(can_eti_pkg::ADDR_CONTROL, 16'h0008);
    repeat (14) ev(0, 4'h8);
    repeat (6) ev(0, 4'h1);
    ev(0, 4'h8);
    chk_reg(can_eti_pkg::ADDR_FAULT_TALLY, 16'h7e00);
    ev(0, 4'h8);
    chk_reg(can_eti_pkg::ADDR_FAULT_TALLY, 16'hfe00);
    ev(1, 4'h0);
    chk_reg(can_eti_pkg::ADDR_FAULT_TALLY, 16'h7d00);
    // Outbound tally to its top and into bus-off
    repeat (30) ev(2, 4'h8);
    ev(2, 4'h7);
    ev(2, 4'h8);
    chk_reg(can_eti_pkg::ADDR_FAULT_TALLY, 16'h7dff);
    chk_bit(halt_hold, 1'b0);
    ev(2, 4'h8);
    chk_reg(can_eti_pkg::ADDR_FAULT_TALLY, 16'h7dff);
    chk_bit(halt_hold, 1'b1);
    ev(4, 4'h0);
    chk_reg(can_eti_pkg::ADDR_INT_CAUSE, 16'h8000);
    rd(can_eti_pkg::ADDR_STATUS, d);
    chk_reg(can_eti_pkg::ADDR_INT_CAUSE, 16'h0000);
    $display("test tallies finished");
    // Timing write refused without config enable, then random settings
    wr(can_eti_pkg::ADDR_BIT_TIMING, 16'h0000);
    chk_reg(can_eti_pkg::ADDR_BIT_TIMING, 16'h2301);
    wr(can_eti_pkg::ADDR_PRESC_EXT, 16'h000f);
    chk_reg(can_eti_pkg::ADDR_PRESC_EXT, 16'h0000);
    chk_reg(8'h1c, 16'h0000);
    wr(can_eti_pkg::ADDR_CONTROL, 16'h0041);
    repeat (3) begin
      seed = lfsr_next(seed);
      v = {1'b0, seed[2:0], (seed[6:3] == 4'h0) ? 4'h1 : seed[6:3], seed[8:7], seed[14:9]};
      wr(can_eti_pkg::ADDR_BIT_TIMING, v);
      chk_reg(can_eti_pkg::ADDR_BIT_TIMING, v);
      chk_word({4'h0, phase_seg2_tq, time_seg1_tq, jump_width_tq},
               {4'h0, {1'b0, v[14:12]} + 4'h1, {1'b0, v[11:8]} + 5'h01,
                {1'b0, v[7:6]} + 3'h1});
      wait_tick(n);
      wait_tick(n);
      chk_word(16'(n), {10'h000, v[5:0]} + 16'h0001);
    end
    // Extension widens the divider above the six-bit field
    wr(can_eti_pkg::ADDR_PRESC_EXT, 16'h0001);
    chk_reg(can_eti_pkg::ADDR_PRESC_EXT, 16'h0001);
    wait_tick(n);
    wait_tick(n);
    chk_word(16'(n), {10'h001, v[5:0]} + 16'h0001);
    $display("test timing finished");
    // Object causes in priority order, corners then random
    pv[0] = 32'h0;
    pv[1] = 32'h80000000;
    seed = lfsr_next(seed);
    pv[2] = seed;
    seed = lfsr_next(seed);
    pv[3] = seed & 32'hfffffff0;
    wr(can_eti_pkg::ADDR_CONTROL, 16'h0002);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) pend <= pv[i];
      repeat (3) @(posedge clk);
      chk_reg(can_eti_pkg::ADDR_INT_CAUSE, exp_cause(pv[i], 1'b0));
      chk_bit(irq, pv[i] != 32'h0);
    end
    // Status cause overrides, then read-clear and retiring objects
    wr(can_eti_pkg::ADDR_CONTROL, 16'h0006);
    @(posedge clk) pend <= 32'h00000030;
    ev(3, 4'h3);
    repeat (3) @(posedge clk);
    chk_reg(can_eti_pkg::ADDR_INT_CAUSE, exp_cause(32'h30, 1'b1));
    rd(can_eti_pkg::ADDR_STATUS, d);
    repeat (3) @(posedge clk);
    chk_reg(can_eti_pkg::ADDR_INT_CAUSE, 16'h0005);
    // A first successful transmission is a status change of its own
    ev(5, 4'h0);
    repeat (3) @(posedge clk);
    chk_reg(can_eti_pkg::ADDR_INT_CAUSE, 16'h8000);
    rd(can_eti_pkg::ADDR_STATUS, d);
    chk_word(d, 16'h001b);
    @(posedge clk) pend <= 32'h00000020;
    repeat (3) @(posedge clk);
    chk_reg(can_eti_pkg::ADDR_INT_CAUSE, 16'h0006);
    @(posedge clk) pend <= 32'h0;
    repeat (3) @(posedge clk);
    chk_reg(can_eti_pkg::ADDR_INT_CAUSE, 16'h0000);
    chk_bit(irq, 1'b0);
    @(posedge clk) pend <= 32'h1;
    repeat (3) @(posedge clk);
    #1 chk_bit(irq, 1'b1);
    wr(can_eti_pkg::ADDR_CONTROL, 16'h0004);
    repeat (3) @(posedge clk);
    chk_bit(irq, 1'b0);
    $display("test interrupts finished");
    // Diagnostic writes are ignored until access is enabled
    wr(can_eti_pkg::ADDR_CONTROL, 16'h0000);
    wr(can_eti_pkg::ADDR_DIAG, 16'h0060);
    chk_reg(can_eti_pkg::ADDR_DIAG, 16'h0080);
    wr(can_eti_pkg::ADDR_CONTROL, 16'h0080);
    for (int m = 0; m < 4; m++) begin
      wr(can_eti_pkg::ADDR_DIAG, {9'h000, 2'(m), 5'h00});
      for (int j = 0; j < 4; j++) begin
        seed = lfsr_next(seed);
        nd = seed[0];
        @(posedge clk);
        core_tx <= j[0];
        sample_point <= j[1];
        node_dom <= nd;
        #1 chk_bit(can_tx, exp_tx(m, j[0], j[1]));
        chk_bit(tx_inhibit, m != 0);
      end
      chk_reg(can_eti_pkg::ADDR_DIAG, {8'h00, exp_tx(m, 1'b1, 1'b1) & ~nd, 2'(m), 5'h00});
    end
    // Loop-back, listen-only and direct buffer, then leave test mode
    wr(can_eti_pkg::ADDR_DIAG, 16'h001c);
    @(posedge clk);
    core_tx <= 1'b0;
    node_dom <= 1'b0;
    #1 chk_bit(core_rx, 1'b0);
    chk_bit(can_tx, 1'b1);
    chk_word({13'h0, loopback_active, listen_only_active, direct_buffer_mode}, 16'h7);
    wr(can_eti_pkg::ADDR_CONTROL, 16'h0000);
    #1 chk_word({13'h0, loopback_active, listen_only_active, direct_buffer_mode}, 16'h0);
    $display("test diagnostics finished");
    report_and_stop();
  end
endmodule // can_error_timing_irq_test_tb_top

// [verilog/can_error_timing_irq_test.sv]
// Error tallies, bit timing, interrupt cause and diagnostic pin control of a CAN controller
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps

module can_error_timing_irq_test (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire can_eti_pkg::reg_req_type reg_req,
  output logic [15:0] reg_rdata,
  // Protocol engine events
  input wire logic rx_error,
  input wire logic [3:0] rx_error_inc,
  input wire logic rx_done,
  input wire logic tx_error,
  input wire logic [3:0] tx_error_inc,
  input wire logic tx_done,
  input wire logic lec_valid,
  input wire logic [2:0] lec_code,
  input wire logic recovery_done,
  input wire logic [31:0] object_pending_flag,
  // Protocol engine bit stream
  input wire logic core_tx,
  input wire logic sample_point,
  output logic core_rx,
  // Bus pins
  input wire logic can_rx,
  output logic can_tx,
  // Configuration to the protocol engine
  output logic tq_tick,
  output logic [3:0] phase_seg2_tq,
  output logic [4:0] time_seg1_tq,
  output logic [2:0] jump_width_tq,
  output logic halt_hold,
  output logic tx_inhibit,
  output logic loopback_active,
  output logic listen_only_active,
  output logic direct_buffer_mode,
  // Processor interrupt
  output logic irq
);

  can_eti_pkg::state_type st;
  can_eti_pkg::state_type next_st;

  logic wr_ctl, wr_stat, wr_bt, wr_diag, wr_ext, rd_stat;
  logic timing_open;
  logic [7:0] rec_sum;
  logic [8:0] tec_sum;
  logic warn, err_passive, warn_next, status_evt;
  logic [15:0] next_cause;
  logic [9:0] divisor;

  // Address decode; strobes are one cycle and never overlap
  assign wr_ctl = reg_req.wr && reg_req.addr == can_eti_pkg::ADDR_CONTROL;
  assign wr_stat = reg_req.wr && reg_req.addr == can_eti_pkg::ADDR_STATUS;
  assign wr_bt = reg_req.wr && reg_req.addr == can_eti_pkg::ADDR_BIT_TIMING;
  assign wr_diag = reg_req.wr && reg_req.addr == can_eti_pkg::ADDR_DIAG;
  assign wr_ext = reg_req.wr && reg_req.addr == can_eti_pkg::ADDR_PRESC_EXT;
  assign rd_stat = reg_req.rd && reg_req.addr == can_eti_pkg::ADDR_STATUS;
  assign timing_open = st.halt && st.cfg_en;

  // Candidate tally sums, one bit wider so the threshold is visible
  assign rec_sum = {1'b0, st.inbound_fault_tally} + {4'h0, rx_error_inc};
  assign tec_sum = {1'b0, st.outbound_fault_tally} + {5'h00, tx_error_inc};

  // Warning and passive levels derived from the tallies
  assign warn = st.bus_off || st.passive || {1'b0, st.inbound_fault_tally} >= can_eti_pkg::WARN_LEVEL
    || st.outbound_fault_tally >= can_eti_pkg::WARN_LEVEL;
  assign err_passive = st.bus_off || st.passive
    || st.outbound_fault_tally >= can_eti_pkg::OUTBOUND_PASSIVE_LEVEL;
  assign divisor = {st.presc_ext, st.presc};

  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.tq_tick = 1'b0;

    // Control register writes
    if (wr_ctl) begin
      next_st.halt = reg_req.wdata[can_eti_pkg::CTL_HALT];
      next_st.line_en = reg_req.wdata[can_eti_pkg::CTL_LINE_EN];
      next_st.stat_en = reg_req.wdata[can_eti_pkg::CTL_STAT_EN];
      next_st.err_en = reg_req.wdata[can_eti_pkg::CTL_ERR_EN];
      next_st.cfg_en = reg_req.wdata[can_eti_pkg::CTL_CFG_EN];
      next_st.diag_en = reg_req.wdata[can_eti_pkg::CTL_DIAG_EN];
    end

    // Software writes to status; hardware sets below still win
    if (wr_stat) begin
      next_st.rx_ok = reg_req.wdata[4];
      next_st.tx_ok = reg_req.wdata[3];
      next_st.lec = reg_req.wdata[2:0];
    end

    // Bit timing, only while halted with configuration enable set
    if (wr_bt && timing_open) begin
      next_st.seg2 = reg_req.wdata[can_eti_pkg::BT_SEG2_LO +: 3];
      next_st.seg1 = reg_req.wdata[can_eti_pkg::BT_SEG1_LO +: 4];
      next_st.resync_jump_width = reg_req.wdata[can_eti_pkg::BT_SJW_LO +: 2];
      next_st.presc = reg_req.wdata[can_eti_pkg::BT_PRESC_LO +: 6];
    end
    if (wr_ext && timing_open) begin
      next_st.presc_ext = reg_req.wdata[3:0];
    end

    // Diagnostic settings need diag access enabled
    if (wr_diag && st.diag_en) begin
      next_st.tx_ovr = reg_req.wdata[can_eti_pkg::DG_TX_LO +: 2];
      next_st.loopback = reg_req.wdata[can_eti_pkg::DG_LOOP];
      next_st.listen_only = reg_req.wdata[can_eti_pkg::DG_LISTEN];
      next_st.direct_buf = reg_req.wdata[can_eti_pkg::DG_DIRECT];
    end

    // Inbound tally: saturate into the passive flag instead of wrapping
    if (rx_error) begin
      if (rec_sum >= can_eti_pkg::INBOUND_PASSIVE_LEVEL) begin
        next_st.passive = 1'b1;
      end else begin
        next_st.inbound_fault_tally = rec_sum[6:0];
      end
    end else if (rx_done) begin
      if (st.passive) begin
        next_st.passive = 1'b0;
      end
      if (st.inbound_fault_tally != 7'h00) begin
        next_st.inbound_fault_tally = st.inbound_fault_tally - 7'h01;
      end
    end

    // Outbound tally: reaching 256 halts the node
    if (tx_error) begin
      if (tec_sum >= can_eti_pkg::OUTBOUND_OFF_LEVEL) begin
        next_st.halt = 1'b1;
        next_st.bus_off = 1'b1;
      end else begin
        next_st.outbound_fault_tally = tec_sum[7:0];
      end
    end else if (tx_done && st.outbound_fault_tally != 8'h00) begin
      next_st.outbound_fault_tally = st.outbound_fault_tally - 8'h01;
    end

    // Bus-off recovery sequence completed elsewhere resets the tallies
    if (recovery_done) begin
      next_st.bus_off = 1'b0;
      next_st.passive = 1'b0;
      next_st.inbound_fault_tally = 7'h00;
      next_st.outbound_fault_tally = 8'h00;
    end

    // Hardware status updates
    if (rx_done) begin
      next_st.rx_ok = 1'b1;
    end
    if (tx_done) begin
      next_st.tx_ok = 1'b1;
    end
    if (lec_valid) begin
      next_st.lec = lec_code;
    end

    // Status change events, only those made by hardware count
    warn_next = next_st.bus_off || next_st.passive || {1'b0, next_st.inbound_fault_tally} >=
      can_eti_pkg::WARN_LEVEL || next_st.outbound_fault_tally >= can_eti_pkg::WARN_LEVEL;
    status_evt = (st.err_en && (next_st.bus_off != st.bus_off || warn_next != warn))
      || (st.stat_en && ((rx_done && !st.rx_ok) || (tx_done && !st.tx_ok)
      || (lec_valid && lec_code != st.lec)));

    // Status cause: a new event beats a clearing read in the same cycle
    if (status_evt) begin
      next_st.status_cause = 1'b1;
    end else if (rd_stat) begin
      next_st.status_cause = 1'b0;
    end

    // Priority encode: status first, then lowest object number
    next_cause = can_eti_pkg::CAUSE_NONE;
    for (int i = can_eti_pkg::NUM_OBJECTS - 1; i >= 0; i--) begin
      if (object_pending_flag[i]) begin
        next_cause = 16'(i + 1);
      end
    end
    if (st.status_cause) begin
      next_cause = can_eti_pkg::CAUSE_STATUS;
    end
    next_st.cause = next_cause;

    // Time quantum prescaler
    if (st.presc_cnt >= divisor) begin
      next_st.presc_cnt = 10'h000;
      next_st.tq_tick = 1'b1;
    end else begin
      next_st.presc_cnt = st.presc_cnt + 10'h001;
    end

    // Read data, registered so it appears the cycle after the strobe
    next_st.rdata = 16'h0000;
    if (reg_req.rd) begin
      case (reg_req.addr)
        can_eti_pkg::ADDR_CONTROL: begin
          next_st.rdata[can_eti_pkg::CTL_HALT] = st.halt;
          next_st.rdata[can_eti_pkg::CTL_LINE_EN] = st.line_en;
          next_st.rdata[can_eti_pkg::CTL_STAT_EN] = st.stat_en;
          next_st.rdata[can_eti_pkg::CTL_ERR_EN] = st.err_en;
          next_st.rdata[can_eti_pkg::CTL_CFG_EN] = st.cfg_en;
          next_st.rdata[can_eti_pkg::CTL_DIAG_EN] = st.diag_en;
        end
        can_eti_pkg::ADDR_STATUS: begin
          next_st.rdata[7:0] = {st.bus_off, warn, err_passive, st.rx_ok, st.tx_ok, st.lec};
        end
        can_eti_pkg::ADDR_FAULT_TALLY: begin
          next_st.rdata = {st.passive, st.inbound_fault_tally, st.outbound_fault_tally};
        end
        can_eti_pkg::ADDR_BIT_TIMING: begin
          next_st.rdata = {1'b0, st.seg2, st.seg1, st.resync_jump_width, st.presc};
        end
        can_eti_pkg::ADDR_INT_CAUSE: begin
          next_st.rdata = st.cause;
        end
        can_eti_pkg::ADDR_DIAG: begin
          next_st.rdata[can_eti_pkg::DG_RX_MON] = can_rx;
          next_st.rdata[can_eti_pkg::DG_TX_LO +: 2] = st.tx_ovr;
          next_st.rdata[can_eti_pkg::DG_LOOP] = st.loopback;
          next_st.rdata[can_eti_pkg::DG_LISTEN] = st.listen_only;
          next_st.rdata[can_eti_pkg::DG_DIRECT] = st.direct_buf;
        end
        can_eti_pkg::ADDR_PRESC_EXT: begin
          next_st.rdata[3:0] = st.presc_ext;
        end
        default: begin
          next_st.rdata = 16'h0000; // Unmapped reads as zero
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= can_eti_pkg::STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Diagnostic settings act only while diag access stays enabled
  logic [1:0] ovr_eff;
  assign ovr_eff = st.diag_en ? st.tx_ovr : can_eti_pkg::TXO_NORMAL;
  assign loopback_active = st.diag_en && st.loopback;
  assign listen_only_active = st.diag_en && st.listen_only;
  assign direct_buffer_mode = st.diag_en && st.direct_buf;
  assign tx_inhibit = ovr_eff != can_eti_pkg::TXO_NORMAL;

  // Transmit pin; listen-only keeps the pin recessive in normal mode
  always_comb begin
    case (ovr_eff)
      can_eti_pkg::TXO_NORMAL: can_tx = core_tx || listen_only_active || loopback_active;
      can_eti_pkg::TXO_SAMPLE: can_tx = sample_point;
      can_eti_pkg::TXO_DOMINANT: can_tx = 1'b0;
      can_eti_pkg::TXO_RECESSIVE: can_tx = 1'b1;
      default: can_tx = 1'b1;
    endcase
  end

  // Loop-back feeds the engine its own stream, ignoring the bus
  assign core_rx = loopback_active ? core_tx : can_rx;

  // Outputs to engine and processor
  assign reg_rdata = st.rdata;
  assign tq_tick = st.tq_tick;
  assign phase_seg2_tq = {1'b0, st.seg2} + 4'h1;
  assign time_seg1_tq = {1'b0, st.seg1} + 5'h01;
  assign jump_width_tq = {1'b0, st.resync_jump_width} + 3'h1;
  assign halt_hold = st.halt;
  assign irq = st.line_en && st.cause != can_eti_pkg::CAUSE_NONE;

  // Checks
  sequence s_rx_saturate;
    rx_error && rec_sum >= can_eti_pkg::INBOUND_PASSIVE_LEVEL && !recovery_done;
  endsequence

  sequence s_tx_overflow;
    tx_error && tec_sum >= can_eti_pkg::OUTBOUND_OFF_LEVEL && !recovery_done;
  endsequence

  chk_rec_saturate: assert property (@(posedge clk) disable iff (sys_rst)
    s_rx_saturate |=> st.passive && st.inbound_fault_tally == $past(st.inbound_fault_tally))
    else $error("inbound tally not held at passive level");

  chk_rec_increment: assert property (@(posedge clk) disable iff (sys_rst)
    rx_error && rec_sum < 8'h80 && !recovery_done |=> st.inbound_fault_tally == $past(rec_sum[6:0]))
    else $error("inbound tally increment wrong");

  chk_rec_recover: assert property (@(posedge clk) disable iff (sys_rst)
    rx_done && !rx_error && !recovery_done && st.passive && st.inbound_fault_tally == 7'h7e
    |=> st.inbound_fault_tally == 7'h7d && !st.passive)
    else $error("passive recovery wrong");

  chk_tec_busoff: assert property (@(posedge clk) disable iff (sys_rst)
    s_tx_overflow |=> halt_hold && st.bus_off && st.outbound_fault_tally == $past(st.outbound_fault_tally))
    else $error("outbound overflow did not halt");

  chk_tec_increment: assert property (@(posedge clk) disable iff (sys_rst)
    tx_error && tec_sum < 9'h100 && !recovery_done |=> st.outbound_fault_tally == $past(tec_sum[7:0]))
    else $error("outbound tally increment wrong");

  chk_timing_locked: assert property (@(posedge clk) disable iff (sys_rst)
    wr_bt && !timing_open |=> $stable({st.seg2, st.seg1, st.resync_jump_width, st.presc}))
    else $error("bit timing changed while locked");

  chk_status_first: assert property (@(posedge clk) disable iff (sys_rst)
    st.status_cause |=> st.cause == can_eti_pkg::CAUSE_STATUS)
    else $error("status cause not on top");

  chk_lowest_object: assert property (@(posedge clk) disable iff (sys_rst)
    !st.status_cause && object_pending_flag[0] |=> st.cause == 16'h0001)
    else $error("object one not ranked first");

  chk_status_clear: assert property (@(posedge clk) disable iff (sys_rst)
    rd_stat && !status_evt |=> !st.status_cause ##1 st.cause != can_eti_pkg::CAUSE_STATUS)
    else $error("status read did not clear cause");

  chk_tx_forced: assert property (@(posedge clk) disable iff (sys_rst)
    st.diag_en && st.tx_ovr == can_eti_pkg::TXO_DOMINANT |-> !can_tx && tx_inhibit)
    else $error("forced dominant not driven");

  chk_irq_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    !st.status_cause && object_pending_flag == 32'h0 |=> !irq)
    else $error("interrupt line active with no cause");

  chk_ext_locked: assert property (@(posedge clk) disable iff (sys_rst)
    wr_ext && !timing_open |=> $stable(st.presc_ext))
    else $error("prescaler extension changed while locked");

  chk_diag_locked: assert property (@(posedge clk) disable iff (sys_rst)
    wr_diag && !st.diag_en |=> $stable({st.tx_ovr, st.loopback, st.listen_only, st.direct_buf}))
    else $error("diagnostic settings changed while locked");

  chk_tick_spacing: assert property (@(posedge clk) disable iff (sys_rst)
    tq_tick && divisor != 10'h000 |=> !tq_tick)
    else $error("quantum tick repeated with divider above one");

  chk_status_post: assert property (@(posedge clk) disable iff (sys_rst)
    status_evt |=> st.status_cause ##1 st.cause == can_eti_pkg::CAUSE_STATUS)
    else $error("status event did not post its cause");

endmodule // can_error_timing_irq_test
